/* File: dv/dpw_bus_ctrl_model.sv */
// Behavioural two-wire bus controller that frames wiper updates for the target.
// Assumes the bench resolves the open-drain data wire with a pull-up and calls its tasks.
`timescale 1ns/1ps
module dpw_bus_ctrl_model (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Each step lasts five system cycles (scl high for five, low for ten) so the target's pin synchronisers settle.
  localparam int HALF = 5;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic start_cond();
    sda_low_o = 1'b0;
    scl_o = 1'b1;
    wait_n(HALF);
    sda_low_o = 1'b1;
    wait_n(HALF);
    scl_o = 1'b0;
    wait_n(HALF);
  endtask

  task automatic stop_cond();
    sda_low_o = 1'b1;
    wait_n(HALF);
    scl_o = 1'b1;
    wait_n(HALF);
    sda_low_o = 1'b0;
    wait_n(HALF);
  endtask

  // Sends one byte most significant bit first, then releases the wire and samples the acknowledge.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = ~b[i];
      wait_n(HALF);
      scl_o = 1'b1;
      wait_n(HALF);
      scl_o = 1'b0;
      wait_n(HALF);
    end
    sda_low_o = 1'b0;
    wait_n(HALF);
    scl_o = 1'b1;
    wait_n(3);
    ack = ~sda_i;
    wait_n(2);
    scl_o = 1'b0;
    wait_n(HALF);
  endtask
endmodule

/* File: dv/dpw_top_test.sv */
// Self-checking bench for the dual wiper two-wire target.
// Assumes the controller model drives the pins and the wire has a pull-up.
`timescale 1ns/1ps
module dpw_top_test;
  import dpw_pkg::*;

  logic clk;
  logic arst_n;
  logic scl;
  logic sda_low;
  logic sda_w;
  logic sda_drv;
  logic sda_oe;
  logic [2:0] sel;
  logic [TAP_W-1:0] wa;
  logic [TAP_W-1:0] wb;
  logic [TAP_W-1:0] ea;
  logic [TAP_W-1:0] eb;
  logic [3:0] acks;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  assign sda_w = ~((sda_oe & ~sda_drv) | sda_low);

  dpw_top u_dpw_top (.clk_sys_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_drv),
    .sda_oe_o(sda_oe), .addr_select_pin_hi_i(sel[2]), .addr_select_pin_mid_i(sel[1]),
    .addr_select_pin_lo_i(sel[0]), .first_wiper_output_o(wa), .second_wiper_output_o(wb));

  dpw_bus_ctrl_model u_dpw_bus_ctrl_model (.clk_sys_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

  // ----------------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sends up to nb bytes, stopping early when a byte is not acknowledged.
  task automatic frame(input logic [6:0] a, input logic rw, input logic [7:0] c, input logic [7:0] d,
    input int nb);
    logic [7:0] b [4];
    logic k;
    b[0] = {a, rw};
    b[1] = c;
    b[2] = d;
    b[3] = 8'h5A;
    acks = 4'h0;
    u_dpw_bus_ctrl_model.start_cond();
    for (int i = 0; i < nb; i++) begin
      u_dpw_bus_ctrl_model.send_byte(b[i], k);
      acks[i] = k;
      if (k !== 1'b1) break;
    end
    u_dpw_bus_ctrl_model.stop_cond();
  endtask

  task automatic upd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d, input int nb,
    input logic [3:0] xa);
    frame(a, ADDR_RW_WRITE, c, d, nb);
    chk({4'h0, acks}, {4'h0, xa});
    chk(wa, ea);
    chk(wb, eb);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    sel = 3'h0;
    ea = MIDSCALE;
    eb = MIDSCALE;
    repeat (3) @(negedge clk);
    chk(wa, MIDSCALE);
    chk({7'h00, sda_oe}, 8'h00);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(wb, 8'h80);
    ea = 8'h00;
    upd({ADDR_FIXED, sel}, CMD_FIRST, 8'h00, 3, 4'h7);
    eb = 8'hFF;
    upd({ADDR_FIXED, sel}, CMD_SECOND, 8'hFF, 3, 4'h7);
    ea = 8'hA5;
    eb = 8'hA5;
    upd({ADDR_FIXED, sel}, CMD_DUAL, 8'hA5, 3, 4'h7);
    upd({ADDR_FIXED, sel}, 8'h14, 8'h3C, 3, 4'h7);
    upd({ADDR_FIXED, sel}, 8'h10, 8'h3C, 3, 4'h7);
    upd({ADDR_FIXED, sel}, 8'h01, 8'h3C, 3, 4'h7);
    upd({ADDR_FIXED, 3'h1}, CMD_FIRST, 8'h11, 3, 4'h0);
    upd({4'h6, sel}, CMD_DUAL, 8'h11, 3, 4'h0);
    frame({ADDR_FIXED, sel}, 1'b1, CMD_FIRST, 8'h22, 1);
    chk({4'h0, acks}, 8'h00);
    chk(wa, ea);
    // A frame cut after its command byte by a repeated start must not apply the dual command.
    u_dpw_bus_ctrl_model.start_cond();
    u_dpw_bus_ctrl_model.send_byte({ADDR_FIXED, sel, ADDR_RW_WRITE}, acks[0]);
    u_dpw_bus_ctrl_model.send_byte(CMD_DUAL, acks[1]);
    chk({6'h00, acks[1:0]}, 8'h03);
    ea = 8'h3C;
    upd({ADDR_FIXED, sel}, CMD_FIRST, 8'h3C, 4, 4'h7);
    for (int p = 0; p < 8; p++) begin
      sel = p[2:0];
      repeat (4) @(negedge clk);
      eb = {p[2:0], 5'h15};
      upd({ADDR_FIXED, sel}, CMD_SECOND, eb, 3, 4'h7);
      upd({ADDR_FIXED, sel ^ 3'h4}, CMD_SECOND, 8'h00, 3, 4'h0);
    end
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(wa, MIDSCALE);
    chk(wb, MIDSCALE);
    final_report();
  end
endmodule

/* File: logic/dpw_pkg.sv */
// Shared constants and types for the dual wiper two-wire target.
// Assumes a single system clock and a synchronised active-low reset.
package dpw_pkg;

  localparam int TAP_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam int BYTE_IDX_W = 2;

  // Command bytes that select the volatile wiper registers.
  localparam logic [7:0] CMD_FIRST = 8'h11;
  localparam logic [7:0] CMD_SECOND = 8'h12;
  localparam logic [7:0] CMD_DUAL = 8'h13;

  // Fixed upper nibble of the 7-bit target address.
  localparam logic [3:0] ADDR_FIXED = 4'h5;
  localparam logic ADDR_RW_WRITE = 1'h0;

  // Positions of the bytes inside one update frame.
  localparam logic [BYTE_IDX_W-1:0] IDX_ADDR = 2'h0;
  localparam logic [BYTE_IDX_W-1:0] IDX_CMD = 2'h1;
  localparam logic [BYTE_IDX_W-1:0] IDX_DATA = 2'h2;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

  // Wiper value after reset.
  localparam logic [TAP_W-1:0] MIDSCALE = 8'h80;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK_WAIT,
    ST_ACK_DRIVE,
    ST_SKIP
  } dpw_state_t;

endpackage

/* File: logic/dpw_top.sv */
// Two-wire write-only target that sets the taps of two 256-position wipers.
// Assumes scl and sda arrive asynchronously from pins and sda is open drain.
//
// Behaviour
// - Command 0x11 then a data byte loads the first wiper register.
// - Command 0x12 then a data byte loads the second wiper register.
// - Command 0x13 then a data byte loads both wipers with the same byte.
// - The data byte maps bit for bit onto the tap index.
// - Each wiper has 256 taps, indexed 0 to 255.
// - The target never drives read data; only writes are used.
// - A completed write is stored and the wiper output follows it.
// - Address is 0101 followed by the three address-select pins.
`timescale 1ns/1ps
module dpw_top (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_select_pin_hi_i,
  input wire logic addr_select_pin_mid_i,
  input wire logic addr_select_pin_lo_i,
  output logic [dpw_pkg::TAP_W-1:0] first_wiper_output_o,
  output logic [dpw_pkg::TAP_W-1:0] second_wiper_output_o
);
  import dpw_pkg::*;

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1 <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_s1 <= 1'h1;
      rst_n <= rst_s1;
    end
  end

  // Idle bus levels are high, so the scl and sda synchronisers reset high to avoid a false start; the address-pin bits reset low.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 5'h03;
      pin_s2 <= 5'h03;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      pin_s1 <= {addr_select_pin_hi_i, addr_select_pin_mid_i, addr_select_pin_lo_i, scl_i, sda_i};
      pin_s2 <= pin_s1;
      scl_q <= pin_s2[1];
      sda_q <= pin_s2[0];
    end
  end

  // ----------------------------------------------------------------
  // Bus condition decode
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic [2:0] addr_pins;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_s = pin_s2[1];
  assign sda_s = pin_s2[0];
  assign addr_pins = pin_s2[4:2];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // Byte receiver state
  // ----------------------------------------------------------------
  dpw_state_t state;
  dpw_state_t next_state;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [BYTE_IDX_W-1:0] byte_idx;
  logic [TAP_W-1:0] shift;
  logic [TAP_W-1:0] cmd_q;
  logic sda_oe;
  logic sda_drv;

  logic [TAP_W-1:0] rx_byte;
  logic byte_done;
  logic addr_ok;
  logic data_done;
  logic cmd_first;
  logic cmd_second;
  logic ack_byte;

  assign rx_byte = {shift[TAP_W-2:0], sda_s};
  assign byte_done = (state == ST_RX) && scl_rise && (bit_cnt == LAST_BIT);
  // Only a write-direction address is answered; a read request is never acknowledged.
  assign addr_ok = (rx_byte[7:1] == {ADDR_FIXED, addr_pins}) && (rx_byte[0] == ADDR_RW_WRITE);
  assign data_done = byte_done && (byte_idx == IDX_DATA);
  assign cmd_first = (cmd_q == CMD_FIRST) || (cmd_q == CMD_DUAL);
  assign cmd_second = (cmd_q == CMD_SECOND) || (cmd_q == CMD_DUAL);
  assign ack_byte = (byte_idx == IDX_ADDR) ? addr_ok : 1'h1;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_RX: begin
        if (byte_done) begin
          next_state = ack_byte ? ST_ACK_WAIT : ST_SKIP;
        end
      end
      ST_ACK_WAIT: begin
        if (scl_fall) begin
          next_state = ST_ACK_DRIVE;
        end
      end
      ST_ACK_DRIVE: begin
        // Bytes after the data byte are not acknowledged.
        if (scl_fall) begin
          next_state = (byte_idx == IDX_DATA) ? ST_SKIP : ST_RX;
        end
      end
      default: begin
        next_state = ST_SKIP;
      end
    endcase
    if (start_cond) begin
      next_state = ST_RX;
    end else if (stop_cond) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= '0;
      shift <= '0;
    end else if (start_cond) begin
      bit_cnt <= '0;
    end else if (state == ST_RX && scl_rise) begin
      shift <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      byte_idx <= IDX_ADDR;
    end else if (start_cond) begin
      byte_idx <= IDX_ADDR;
    end else if (state == ST_ACK_DRIVE && scl_fall && byte_idx != IDX_DATA) begin
      byte_idx <= byte_idx + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
    end else if (byte_done && byte_idx == IDX_CMD) begin
      cmd_q <= rx_byte;
    end
  end

  // The pin is only ever pulled low for an acknowledge; no data is sent back.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe <= 1'h0;
      sda_drv <= 1'h0;
    end else begin
      sda_oe <= (next_state == ST_ACK_DRIVE);
      sda_drv <= 1'h0;
    end
  end

  assign sda_oe_o = sda_oe;
  assign sda_o = sda_drv;

  // ----------------------------------------------------------------
  // Wiper register writes
  // ----------------------------------------------------------------
  dpw_wr_if wif ();

  // Unknown commands raise neither strobe, so both wipers keep their taps.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wif.wr_first <= 1'h0;
      wif.wr_second <= 1'h0;
      wif.wr_data <= '0;
    end else begin
      wif.wr_first <= data_done && cmd_first;
      wif.wr_second <= data_done && cmd_second;
      if (data_done) begin
        wif.wr_data <= rx_byte;
      end
    end
  end

  dpw_wiper_store u_store (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .wif(wif.store)
  );

  assign first_wiper_output_o = wif.first_tap;
  assign second_wiper_output_o = wif.second_tap;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_data_cmd(logic [7:0] c);
    data_done && cmd_q == c;
  endsequence

  a_first_wiper_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_data_cmd(CMD_FIRST) |-> ##2 first_wiper_output_o == $past(rx_byte, 2) && $stable(second_wiper_output_o))
    else $error("first wiper not loaded by its command");

  a_second_wiper_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_data_cmd(CMD_SECOND) |-> ##2 second_wiper_output_o == $past(rx_byte, 2) && $stable(first_wiper_output_o))
    else $error("second wiper not loaded by its command");

  a_dual_wiper_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_data_cmd(CMD_DUAL) |-> ##2 (first_wiper_output_o == $past(rx_byte, 2))
      && (second_wiper_output_o == $past(rx_byte, 2)))
    else $error("dual command did not load both wipers");

  a_bad_cmd_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    data_done && !cmd_first && !cmd_second |-> ##1 !wif.wr_first && !wif.wr_second ##1
      $stable(first_wiper_output_o) && $stable(second_wiper_output_o))
    else $error("unknown command changed a wiper");

  a_read_never_acked: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    byte_done && byte_idx == IDX_ADDR && rx_byte[0] != ADDR_RW_WRITE |=> !sda_oe_o && state == ST_SKIP)
    else $error("read request was acknowledged");

  a_addr_match_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    byte_done && byte_idx == IDX_ADDR && rx_byte[7:1] == {ADDR_FIXED, addr_pins} && !rx_byte[0]
      && !start_cond && !stop_cond |=> state == ST_ACK_WAIT)
    else $error("matching write address not acknowledged");

  sequence s_ack_start;
    state == ST_ACK_WAIT && scl_fall && !start_cond && !stop_cond;
  endsequence

  a_ack_held_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_ack_start |=> sda_oe_o && !sda_o)
    else $error("acknowledge not driven low");

  a_oe_only_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    sda_oe_o |-> $past(next_state) == ST_ACK_DRIVE)
    else $error("sda driven outside acknowledge");

endmodule

/* File: logic/dpw_wiper_store.sv */
// Volatile storage for the two wiper tap registers.
// Assumes write strobes are one-cycle pulses on the same clock as this store.
`timescale 1ns/1ps
module dpw_wiper_store (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  dpw_wr_if.store wif
);
  import dpw_pkg::*;

  logic [TAP_W-1:0] first_tap;
  logic [TAP_W-1:0] second_tap;

  // A strobe loads the byte as the new tap index; both strobes together update both wipers.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_tap <= MIDSCALE;
      second_tap <= MIDSCALE;
    end else begin
      if (wif.wr_first) begin
        first_tap <= wif.wr_data;
      end
      if (wif.wr_second) begin
        second_tap <= wif.wr_data;
      end
    end
  end

  assign wif.first_tap = first_tap;
  assign wif.second_tap = second_tap;

  property p_store_follows;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wif.wr_first |=> first_tap == $past(wif.wr_data);
  endproperty
  a_store_first_follows: assert property (p_store_follows)
    else $error("first tap did not take written byte");

  property p_reset_mid;
    @(posedge clk_sys_i) $rose(rst_n_i) |-> (first_tap == MIDSCALE && second_tap == MIDSCALE);
  endproperty
  a_reset_midscale_taps: assert property (p_reset_mid) else $error("taps not at midscale after reset");

endmodule

/* File: logic/dpw_wr_if.sv */
// Write strobes and wiper values passed between the bus engine and the wiper store.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface dpw_wr_if;
  import dpw_pkg::*;

  logic wr_first;
  logic wr_second;
  logic [TAP_W-1:0] wr_data;
  logic [TAP_W-1:0] first_tap;
  logic [TAP_W-1:0] second_tap;

  modport ctrl (output wr_first, output wr_second, output wr_data, input first_tap, input second_tap);
  modport store (input wr_first, input wr_second, input wr_data, output first_tap, output second_tap);
endinterface
